// ===== src/frame_clock_device.sv
`default_nettype none
// Contract
// - Interrupt pin drive style by code
// - Shared pin: trigger input or LED4
// - Host selects LED only in internal sync
// - Trigger edge ignored in LED role
// - Broadcast address matches upper seven bits
// - SPI mode ignores broadcast address
// - Broadcast enable accepts writes only
// - SPI broadcast by joint chip-selects
// - Trim two's complement, 0.2% steps
// - Frame timing from 32.768kHz oscillator
// - Host trims from interrupt interval
// - 15-bit divider, high byte resets 0x01
// - Host avoids reserved divider values
// - Host fits measurements within frame; host here never checks it
// - Overrun sets invalid-configuration status flag
// - Frame is seven clocks plus measurements
// - Burst form of measurement time
// - Ambient filter form of measurement time
// - Disabled measurement contributes zero
// - Frame clock period, round up
// - Trigger edge select falling or rising; edge fixed to falling here
module frame_clock_device
  import frame_clock_pkg::*;
#(
  parameter logic [6:0] OWN_I2C_ADDR = 7'h2a, // arbitrary value
  parameter int MEAS_COUNT = 6
)
(
  input wire logic pclk,
  input wire logic presetn,
  frame_link_if.device link,
  input wire logic [1:0] sync_mode,
  input wire logic [MEAS_COUNT-1:0] meas_enable,
  input wire logic [2*MEAS_COUNT-1:0] meas_tint,
  input wire logic [3*MEAS_COUNT-1:0] meas_burst,
  input wire logic [8*MEAS_COUNT-1:0] meas_settle,
  input wire logic [MEAS_COUNT-1:0] meas_sinc3,
  input wire logic [MEAS_COUNT-1:0] meas_filt,
  input wire logic led4_drive,
  input wire logic irq_event,
  output logic frame_start,
  output logic trigger_pulse,
  output logic [18:0] frame_demand
);
  if (MEAS_COUNT != 6)
  begin : g_count_check
    $error("measurement count must be six");
  end

  logic [1:0] irq_pin_drive_type;
  logic shared_pin_role_select;
  logic [6:0] broadcast_address_field;
  logic broadcast_write_enable;
  logic [4:0] frame_osc_trim_code;
  logic [6:0] div_high;
  logic [7:0] div_low;
  logic invalid_cfg;
  logic [31:0] osc_phase;
  logic [14:0] frame_count;
  logic trig_meta;
  logic trig_sync;
  logic trig_prev;
  logic irq_active;
  logic sync_input_edge_select;

  // Register writes, unused bits never stored
  // unused bits dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_pin_drive_type <= PIN_SETUP_RST[2:1];
      shared_pin_role_select <= PIN_SETUP_RST[0];
      broadcast_address_field <= BCAST_RST[7:1];
      broadcast_write_enable <= BCAST_RST[0];
      frame_osc_trim_code <= TRIM_RST[4:0];
      div_high <= DIV_HIGH_RST;
      div_low <= DIV_LOW_RST;
    end
    else if (link.req_wr)
    begin
      if (link.req_addr == PIN_SETUP_OFF)
      begin
        irq_pin_drive_type <= link.req_wdata[2:1];
        shared_pin_role_select <= link.req_wdata[0];
      end
      else if (link.req_addr == BCAST_OFF)
      begin
        broadcast_address_field <= link.req_wdata[7:1];
        broadcast_write_enable <= link.req_wdata[0];
      end
      else if (link.req_addr == TRIM_OFF)
        frame_osc_trim_code <= link.req_wdata[4:0];
      else if (link.req_addr == DIV_HIGH_OFF)
        div_high <= link.req_wdata[6:0];
      else if (link.req_addr == DIV_LOW_OFF)
        div_low <= link.req_wdata;
    end
  end

  // Read decode
  wire [7:0] read_mux =
    link.req_addr == STATUS_OFF ? {invalid_cfg, 7'h00} :
    link.req_addr == PIN_SETUP_OFF ? {5'h00, irq_pin_drive_type, shared_pin_role_select} :
    link.req_addr == BCAST_OFF ? {broadcast_address_field, broadcast_write_enable} :
    link.req_addr == TRIM_OFF ? {3'h0, frame_osc_trim_code} :
    link.req_addr == DIV_HIGH_OFF ? {1'b0, div_high} :
    link.req_addr == DIV_LOW_OFF ? div_low : 8'h00;
  wire status_read = link.req_rd && link.req_addr == STATUS_OFF;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link.ack <= 1'b0;
      link.rdata <= 8'h00;
    end
    else
    begin
      link.ack <= link.req_wr || link.req_rd;
      link.rdata <= link.req_rd ? read_mux : link.rdata;
    end
  end

  // broadcast match on upper seven bits
  wire bcast_match = link.addr_byte[7:1] == broadcast_address_field;
  wire bcast_write = broadcast_write_enable && bcast_match && !link.addr_byte[0];
  wire next_addr_hit = !link.spi_mode && (link.addr_byte[7:1] == OWN_I2C_ADDR || bcast_write);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      link.addr_hit <= 1'b0;
    else
      link.addr_hit <= link.addr_valid && next_addr_hit;
  end

  wire [31:0] trim_ext = {{27{frame_osc_trim_code[4]}}, frame_osc_trim_code};
  wire [31:0] osc_step = OSC_STEP + 32'(trim_ext * OSC_STEP_LSB);
  wire [32:0] osc_sum = {1'b0, osc_phase} + {1'b0, osc_step};
  // frame clock tick from accumulator carry
  wire frame_tick = osc_sum[32];
  wire [14:0] divider = {div_high, div_low};
  wire frame_wrap = frame_tick && (frame_count + 15'd1 >= divider);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_phase <= 32'h0000_0000;
      frame_count <= 15'h0000;
    end
    else
    begin
      osc_phase <= osc_sum[31:0];
      if (frame_wrap)
        frame_count <= 15'h0000;
      else if (frame_tick)
        frame_count <= frame_count + 15'd1;
    end
  end

  // Per-measurement times, one instance each
  logic [15:0] meas_clocks [MEAS_COUNT];
  genvar m;
  generate
    for (m = 0; m < MEAS_COUNT; m++)
    begin : g_meas
      measurement_time u_meas (
        .enable(meas_enable[m]),
        .tint_sel(meas_tint[2*m +: 2]),
        .burst(meas_burst[3*m +: 3]),
        .settle(meas_settle[8*m +: 8]),
        .sinc3(meas_sinc3[m]),
        .filt(meas_filt[m]),
        .clocks(meas_clocks[m])
      );
    end
  endgenerate

  wire [18:0] demand = 19'(INIT_FRAME_CLOCKS) + 19'(meas_clocks[0]) + 19'(meas_clocks[1]) +
    19'(meas_clocks[2]) + 19'(meas_clocks[3]) + 19'(meas_clocks[4]) + 19'(meas_clocks[5]);
  wire overrun = demand > 19'(divider);

  // sticky flag, set beats read clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      invalid_cfg <= 1'b0;
    else if (frame_wrap && overrun)
      invalid_cfg <= 1'b1;
    else if (status_read)
      invalid_cfg <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frame_start <= 1'b0;
      frame_demand <= 19'h00000;
    end
    else
    begin
      frame_start <= frame_wrap;
      frame_demand <= demand;
    end
  end

  // Pin sampled before any logic looks at it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // Idle level of the pulled-down pin, so reset makes no false edge
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
      trig_prev <= 1'b0;
      trigger_pulse <= 1'b0;
    end
    else
    begin
      trig_meta <= link.shared_wire;
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
      trigger_pulse <= !shared_pin_role_select && (trig_prev != trig_sync) &&
        (trig_sync == sync_input_edge_select);
    end
  end

  // edge bit not held here, falling fixed
  assign sync_input_edge_select = 1'b0;

  // shared pin as LED drive when selected
  // relied on: LED role only with sync mode 0
  assign link.shared_o = led4_drive && sync_mode == 2'h0;
  assign link.shared_oe_n = !shared_pin_role_select;

  assign irq_active = irq_event || invalid_cfg;
  assign link.irq_o = irq_pin_drive_type == IRQ_PUSH_HIGH ? irq_active :
    irq_pin_drive_type == IRQ_PUSH_LOW ? !irq_active : 1'b0;
  assign link.irq_oe_n = irq_pin_drive_type == IRQ_OPEN_DRAIN_LOW ? !irq_active :
    (irq_pin_drive_type == IRQ_PUSH_HIGH || irq_pin_drive_type == IRQ_PUSH_LOW) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ===== src/frame_clock_host.sv
`default_nettype none
module frame_clock_host
  import frame_clock_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  frame_link_if.host link
);
  import frame_clock_pkg::*;
  host_state_t state;
  logic [7:0] cmd_addr;
  logic [7:0] cmd_data;
  logic cmd_write;
  logic [7:0] last_rdata;
  logic refused;
  logic [1:0] sync_mode_copy;
  logic [6:0] div_high_copy;
  logic [7:0] div_low_copy;
  logic addr_ack;
  logic irq_meta;
  logic irq_sync;
  logic irq_prev;
  logic [31:0] irq_timer;
  logic [31:0] irq_period;
  logic trig_level;
  logic trig_drive;

  wire access = psel && penable;
  wire wr_ctrl = access && pwrite && paddr == CTRL_OFF;
  wire wr_probe = access && pwrite && paddr == PROBE_OFF;
  wire wr_pinctl = access && pwrite && paddr == PINCTL_OFF;
  wire mapped = paddr == CTRL_OFF || paddr == HSTAT_OFF || paddr == PROBE_OFF ||
    paddr == PINCTL_OFF || paddr == PERIOD_OFF;
  wire busy = state != H_IDLE;
  wire go = wr_ctrl && !busy && (pwdata[16] || pwdata[17]);
  wire [7:0] go_addr = pwdata[7:0];
  wire [7:0] go_data = pwdata[15:8];
  // LED role refused outside internal sync
  wire bad_led = go_addr == PIN_SETUP_OFF && go_data[0] && sync_mode_copy != 2'h0;
  wire [14:0] div_try = go_addr == DIV_HIGH_OFF ? {go_data[6:0], div_low_copy} :
    {div_high_copy, go_data};
  wire div_write = go_addr == DIV_HIGH_OFF || go_addr == DIV_LOW_OFF;
  wire bad_div = div_write && (div_try == DIV_RESERVED || div_try < DIV_MIN);
  wire refuse = pwdata[16] && (bad_led || bad_div);

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = !psel ? 32'h0 :
    paddr == CTRL_OFF ? {16'h0, cmd_data, cmd_addr} :
    paddr == HSTAT_OFF ? {12'h0, addr_ack, refused, irq_sync, busy, 8'h0, last_rdata} :
    paddr == PINCTL_OFF ? {26'h0, sync_mode_copy, 2'h0, trig_drive, trig_level} :
    paddr == PERIOD_OFF ? irq_period : 32'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= H_IDLE;
      cmd_addr <= 8'h00;
      cmd_data <= 8'h00;
      cmd_write <= 1'b0;
      last_rdata <= 8'h00;
      refused <= 1'b0;
      div_high_copy <= DIV_HIGH_RST;
      div_low_copy <= DIV_LOW_RST;
    end
    else
    begin
      case (state)
        H_IDLE:
        begin
          if (go && !refuse)
          begin
            cmd_addr <= go_addr;
            cmd_data <= go_data;
            cmd_write <= pwdata[16];
            refused <= 1'b0;
            state <= H_REQ;
          end
          else if (go)
            refused <= 1'b1;
        end
        H_REQ:
          state <= H_WAIT;
        H_WAIT:
        begin
          if (link.ack)
          begin
            state <= H_IDLE;
            if (!cmd_write)
              last_rdata <= link.rdata;
            else if (cmd_addr == DIV_HIGH_OFF)
              div_high_copy <= cmd_data[6:0];
            else if (cmd_addr == DIV_LOW_OFF)
              div_low_copy <= cmd_data;
          end
        end
        default:
          state <= H_IDLE;
      endcase
    end
  end

  assign link.req_wr = state == H_REQ && cmd_write;
  assign link.req_rd = state == H_REQ && !cmd_write;
  assign link.req_addr = cmd_addr;
  assign link.req_wdata = cmd_data;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link.addr_valid <= 1'b0;
      link.addr_byte <= 8'h00;
      link.spi_mode <= 1'b0;
      addr_ack <= 1'b0;
      sync_mode_copy <= 2'h0;
      trig_level <= 1'b1;
      trig_drive <= 1'b0;
    end
    else
    begin
      link.addr_valid <= wr_probe;
      if (wr_probe)
      begin
        link.addr_byte <= pwdata[7:0];
        link.spi_mode <= pwdata[8];
      end
      if (link.addr_valid)
        addr_ack <= 1'b0;
      else if (state == H_IDLE && link.addr_hit)
        addr_ack <= 1'b1;
      if (wr_pinctl)
      begin
        trig_level <= pwdata[0];
        trig_drive <= pwdata[1];
        sync_mode_copy <= pwdata[5:4];
      end
    end
  end

  assign link.trig_o = trig_level;
  assign link.trig_oe_n = !trig_drive;

  // interval between interrupt edges for trimming
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_meta <= 1'b1;
      irq_sync <= 1'b1;
      irq_prev <= 1'b1;
      irq_timer <= 32'h0;
      irq_period <= 32'h0;
    end
    else
    begin
      irq_meta <= link.irq_wire;
      irq_sync <= irq_meta;
      irq_prev <= irq_sync;
      if (irq_prev != irq_sync && irq_sync == 1'b0)
      begin
        irq_period <= irq_timer;
        irq_timer <= 32'h0;
      end
      else
        irq_timer <= irq_timer + 32'd1;
    end
  end
endmodule
`default_nettype wire

// ===== src/frame_clock_pkg.sv
`default_nettype none
package frame_clock_pkg;
  // Device register offsets and reset values
  localparam logic [7:0] STATUS_OFF = 8'h01;
  localparam logic [7:0] PIN_SETUP_OFF = 8'h17;
  localparam logic [7:0] BCAST_OFF = 8'h18;
  localparam logic [7:0] TRIM_OFF = 8'h1a;
  localparam logic [7:0] DIV_HIGH_OFF = 8'h1b;
  localparam logic [7:0] DIV_LOW_OFF = 8'h1c;
  localparam logic [7:0] PIN_SETUP_RST = 8'h00;
  localparam logic [7:0] BCAST_RST = 8'h00;
  localparam logic [7:0] TRIM_RST = 8'h00;
  localparam logic [6:0] DIV_HIGH_RST = 7'h01;
  localparam logic [7:0] DIV_LOW_RST = 8'h00;
  localparam int INVALID_BIT = 7;
  // Interrupt drive codes
  localparam logic [1:0] IRQ_OPEN_DRAIN_LOW = 2'h0;
  localparam logic [1:0] IRQ_PUSH_HIGH = 2'h1;
  localparam logic [1:0] IRQ_PUSH_LOW = 2'h2;
  // Divider limits
  localparam logic [14:0] DIV_RESERVED = 15'h7fff;
  localparam logic [14:0] DIV_MIN = 15'h0010;
  // Frame clock from pclk by phase accumulation
  localparam longint PCLK_HZ = 200_000_000;
  localparam longint FRAME_OSC_HZ = 32768;
  localparam logic [31:0] OSC_STEP = 32'((FRAME_OSC_HZ << 32) / PCLK_HZ);
  localparam int TRIM_DIVISOR = 500;
  localparam logic [31:0] OSC_STEP_LSB = 32'(OSC_STEP / TRIM_DIVISOR);
  localparam logic [4:0] INIT_FRAME_CLOCKS = 5'd7;
  localparam logic [15:0] INIT_MEAS_CLOCKS = 16'd3;
  // Tenths of a microsecond to frame clocks, scaled by 2^24, rounded up
  localparam int TENTHS_SHIFT = 24;
  localparam logic [47:0] TENTHS_TO_CLOCKS = 48'd54976;
  // Integration times in tenths of a microsecond
  localparam logic [11:0] TINT_0 = 12'd146;
  localparam logic [11:0] TINT_1 = 12'd292;
  localparam logic [11:0] TINT_2 = 12'd586;
  localparam logic [11:0] TINT_3 = 12'd1171;
  // Host APB map
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] HSTAT_OFF = 12'h004;
  localparam logic [11:0] PROBE_OFF = 12'h008;
  localparam logic [11:0] PINCTL_OFF = 12'h00c;
  localparam logic [11:0] PERIOD_OFF = 12'h010;
  typedef enum logic [1:0] {H_IDLE, H_REQ, H_WAIT} host_state_t;
endpackage
`default_nettype wire

// ===== src/frame_link_if.sv
`default_nettype none
interface frame_link_if;
  logic req_wr;
  logic req_rd;
  logic [7:0] req_addr;
  logic [7:0] req_wdata;
  logic ack;
  logic [7:0] rdata;
  logic addr_valid;
  logic [7:0] addr_byte;
  logic spi_mode;
  logic addr_hit;
  logic irq_o;
  logic irq_oe_n;
  logic shared_o;
  logic shared_oe_n;
  logic trig_o;
  logic trig_oe_n;
  wire irq_wire;
  wire shared_wire;
  // Pull-up on the interrupt line, pull-down on the shared pin
  assign irq_wire = !irq_oe_n ? irq_o : 1'b1;
  assign shared_wire = !shared_oe_n ? shared_o : (!trig_oe_n ? trig_o : 1'b0);
  modport device (input req_wr, req_rd, req_addr, req_wdata, addr_valid, addr_byte, spi_mode,
    shared_wire, output ack, rdata, addr_hit, irq_o, irq_oe_n, shared_o, shared_oe_n);
  modport host (output req_wr, req_rd, req_addr, req_wdata, addr_valid, addr_byte, spi_mode,
    trig_o, trig_oe_n, input ack, rdata, addr_hit, irq_wire);
endinterface
`default_nettype wire

// ===== src/measurement_time.sv
`default_nettype none
module measurement_time
  import frame_clock_pkg::*;
(
  input wire logic enable,
  input wire logic [1:0] tint_sel,
  input wire logic [2:0] burst,
  input wire logic [7:0] settle,
  input wire logic sinc3,
  input wire logic filt,
  output logic [15:0] clocks
);
  logic [11:0] tint_tenths;
  logic [8:0] pulses;
  logic [47:0] long_form;
  logic [47:0] short_form;
  logic [47:0] tenths;
  logic [47:0] scaled;
  assign tint_tenths = tint_sel == 2'd0 ? TINT_0 : tint_sel == 2'd1 ? TINT_1 :
    tint_sel == 2'd2 ? TINT_2 : TINT_3;
  assign pulses = 9'd1 << burst;
  assign long_form = 48'(tint_tenths) * (48'(pulses) * 48'd2 + 48'd1) +
    48'd2 * 48'(pulses) * 48'(settle);
  assign short_form = 48'd2 * 48'(tint_tenths) + 48'(settle);
  assign tenths = (sinc3 || !filt) ? long_form : short_form;
  assign scaled = (tenths * TENTHS_TO_CLOCKS + ((48'd1 << TENTHS_SHIFT) - 48'd1)) >> TENTHS_SHIFT;
  assign clocks = enable ? scaled[15:0] + INIT_MEAS_CLOCKS : 16'd0;
endmodule
`default_nettype wire

// ===== testbench/frame_clock_and_pin_config_tb.sv
`default_nettype none
module frame_clock_and_pin_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import frame_clock_pkg::*;
  localparam logic [6:0] own_addr = 7'h2a; // arbitrary value
  // Entries are {expected hit, spi mode, address byte}
  localparam logic [9:0] probe_tab [7] = '{10'h254, 10'h066, 10'h266, 10'h067, 10'h255,
    10'h166, 10'h154};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] sync_mode;
  logic [5:0] meas_enable, meas_sinc3, meas_filt;
  logic [11:0] meas_tint;
  logic [17:0] meas_burst;
  logic [47:0] meas_settle;
  logic led4_drive, irq_event, frame_start, trigger_pulse;
  logic [18:0] frame_demand;
  int num_errors = 0;
  int checked = 0;
  int trig_seen = 0;

  frame_link_if u_frame_link_if();
  frame_clock_device #(.OWN_I2C_ADDR(own_addr)) u_frame_clock_device(.pclk, .presetn,
    .link(u_frame_link_if.device), .sync_mode, .meas_enable, .meas_tint, .meas_burst,
    .meas_settle, .meas_sinc3, .meas_filt, .led4_drive, .irq_event, .frame_start,
    .trigger_pulse, .frame_demand);
  frame_clock_host u_frame_clock_host(.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .link(u_frame_link_if.host));
  frame_clock_properties #(.OWN_I2C_ADDR(own_addr)) u_frame_clock_properties(.pclk,
    .presetn, .req_wr(u_frame_link_if.req_wr), .req_rd(u_frame_link_if.req_rd),
    .ack(u_frame_link_if.ack), .rdata(u_frame_link_if.rdata),
    .addr_valid(u_frame_link_if.addr_valid), .addr_byte(u_frame_link_if.addr_byte),
    .spi_mode(u_frame_link_if.spi_mode), .addr_hit(u_frame_link_if.addr_hit));

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk)
    if (trigger_pulse === 1'b1)
      trig_seen++;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Starts on a fresh edge so psel is never assigned twice in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Device access through the command register, then poll until idle
  task automatic dev(input logic rd_go, input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, CTRL_OFF, {14'h0, rd_go, !rd_go, d, a});
    do
    begin
      apb(1'b0, HSTAT_OFF, 32'h0);
    end
    while (rd[16] !== 1'b0);
  endtask

  task automatic reg_is(input string what, input logic [7:0] a, input logic [7:0] exp);
    dev(1'b1, a, 8'h00);
    check(what, 32'(rd[7:0]), 32'(exp));
  endtask

  task automatic t_regs;
    reg_is("divider high reset", DIV_HIGH_OFF, 8'h01);
    reg_is("pin setup reset", PIN_SETUP_OFF, 8'h00);
    reg_is("broadcast reset", BCAST_OFF, 8'h00);
    reg_is("trim reset", TRIM_OFF, 8'h00);
    dev(1'b0, TRIM_OFF, 8'hff);
    reg_is("trim unused bits", TRIM_OFF, 8'h1f);
    dev(1'b0, DIV_HIGH_OFF, 8'hff);
    reg_is("divider high unused bit", DIV_HIGH_OFF, 8'h7f);
    dev(1'b0, DIV_HIGH_OFF, 8'h01);
    dev(1'b0, TRIM_OFF, 8'h00);
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped error", 32'(last_err), 32'h1);
    check("unmapped data", rd, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_refuse;
    sync_mode <= 2'h1;
    apb(1'b1, PINCTL_OFF, 32'h10);
    dev(1'b0, PIN_SETUP_OFF, 8'h01);
    check("led role refused", 32'(rd[18]), 32'h1);
    reg_is("pin setup kept", PIN_SETUP_OFF, 8'h00);
    dev(1'b0, DIV_HIGH_OFF, 8'h00);
    check("short divider refused", 32'(rd[18]), 32'h1);
    reg_is("divider kept", DIV_HIGH_OFF, 8'h01);
    apb(1'b1, PINCTL_OFF, 32'h0);
    sync_mode <= 2'h0;
    $display("test refuse done");
  endtask

  task automatic t_irq;
    for (int c = 0; c < 3; c++)
      for (int e = 0; e < 2; e++)
      begin
        dev(1'b0, PIN_SETUP_OFF, 8'(c << 1));
        irq_event <= e[0];
        repeat (4) @(posedge pclk);
        check("irq released", 32'(u_frame_link_if.irq_oe_n), 32'(c == 0 && e == 0));
        check("irq level", 32'(u_frame_link_if.irq_wire), 32'((c == 1) == (e == 1)));
        apb(1'b0, HSTAT_OFF, 32'h0);
        check("irq pin status", 32'(rd[17]), 32'((c == 1) == (e == 1)));
      end
    irq_event <= 1'b0;
    $display("test irq done");
  endtask

  task automatic t_pin;
    dev(1'b0, PIN_SETUP_OFF, 8'h00);
    check("trigger pin released", 32'(u_frame_link_if.shared_oe_n), 32'h1);
    apb(1'b1, PINCTL_OFF, 32'h3);
    repeat (4) @(posedge pclk);
    trig_seen = 0;
    apb(1'b1, PINCTL_OFF, 32'h2);
    // Pulse lands three edges after the pin; count it one edge later
    repeat (6) @(posedge pclk);
    check("falling edge seen", 32'(trig_seen), 32'h1);
    apb(1'b1, PINCTL_OFF, 32'h3);
    repeat (6) @(posedge pclk);
    check("rising edge ignored", 32'(trig_seen), 32'h1);
    apb(1'b1, PINCTL_OFF, 32'h0);
    // Releasing a high pin reads as a falling edge
    repeat (6) @(posedge pclk);
    check("release edge seen", 32'(trig_seen), 32'h2);
    dev(1'b0, PIN_SETUP_OFF, 8'h01);
    for (int v = 1; v >= 0; v--)
    begin
      led4_drive <= v[0];
      repeat (4) @(posedge pclk);
      check("led pin driven", 32'(u_frame_link_if.shared_oe_n), 32'h0);
      check("led pin level", 32'(u_frame_link_if.shared_wire), 32'(v));
    end
    // The led falling edge must not look like a trigger
    check("no trigger in led role", 32'(trig_seen), 32'h2);
    dev(1'b0, PIN_SETUP_OFF, 8'h00);
    $display("test pin done");
  endtask

  task automatic t_addr;
    for (int i = 0; i < 7; i++)
    begin
      if (i == 2)
        dev(1'b0, BCAST_OFF, 8'h67);
      apb(1'b1, PROBE_OFF, {23'h0, probe_tab[i][8:0]});
      repeat (3) @(posedge pclk);
      apb(1'b0, HSTAT_OFF, 32'h0);
      check("address match", 32'(rd[19]), 32'(probe_tab[i][9]));
    end
    dev(1'b0, BCAST_OFF, 8'h00);
    $display("test addr done");
  endtask

  task automatic t_demand;
    meas_tint <= 12'h033;
    meas_burst <= 18'h01007;
    meas_settle <= 48'h000a_0064_00ff;
    meas_sinc3 <= 6'h10;
    meas_filt <= 6'h14;
    repeat (4) @(posedge pclk);
    check("idle frame demand", 32'(frame_demand), 32'd7);
    meas_enable <= 6'h14;
    repeat (4) @(posedge pclk);
    // 7 + (9 + 3) + (3 + 3): burst pulses are two to the code
    check("two measurement demand", 32'(frame_demand), 32'd25);
    meas_enable <= 6'h01;
    repeat (4) @(posedge pclk);
    // 128 pulses: 36622.7 us is 1201 clocks, plus 3 and 7
    check("burst measurement demand", 32'(frame_demand), 32'd1211);
    meas_enable <= 6'h00;
    $display("test demand done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Whole run needs well under a thousand device accesses
  initial
  begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    $display("watchdog expired");
    results();
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sync_mode = 2'h0;
    meas_enable = 6'h00;
    meas_tint = 12'h000;
    meas_burst = 18'h0;
    meas_settle = 48'h0;
    meas_sinc3 = 6'h00;
    meas_filt = 6'h00;
    led4_drive = 1'b0;
    irq_event = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_refuse();
    t_irq();
    t_pin();
    t_addr();
    t_demand();
    results();
  end
endmodule
`default_nettype wire

// ===== testbench/frame_clock_properties.sv
`default_nettype none
module frame_clock_properties #(
  parameter logic [6:0] OWN_I2C_ADDR = 7'h2a // arbitrary value
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req_wr,
  input wire logic req_rd,
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic addr_valid,
  input wire logic [7:0] addr_byte,
  input wire logic spi_mode,
  input wire logic addr_hit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_link_req;
    req_wr || req_rd;
  endsequence

  // Single pulse; host keeps one request outstanding
  sequence s_ack_pulse;
    ack ##1 !ack;
  endsequence

  a_link_ack_pulse: assert property (s_link_req |=> s_ack_pulse)
    else $error("link ack not one cycle after request");
  a_ack_has_cause: assert property (ack |-> $past(req_wr || req_rd))
    else $error("link ack without a request");
  a_rdata_hold: assert property (!(ack && $past(req_rd)) |-> $stable(rdata))
    else $error("link read data changed outside a read");
  a_one_request: assert property (!(req_wr && req_rd))
    else $error("write and read requested together");
  a_hit_needs_probe: assert property (!addr_valid |=> !addr_hit)
    else $error("address hit without an address byte");
  a_spi_no_hit: assert property (addr_valid && spi_mode |=> !addr_hit)
    else $error("address matched in spi mode");
  a_own_addr_hit: assert property (addr_valid && !spi_mode && addr_byte[7:1] == OWN_I2C_ADDR
    |=> addr_hit)
    else $error("own address not matched");
  a_read_not_bcast: assert property (addr_valid && addr_byte[0] &&
    addr_byte[7:1] != OWN_I2C_ADDR |=> !addr_hit)
    else $error("broadcast match on a read");
endmodule
`default_nettype wire
